// file: bfci_pkg.sv
// bfci_pkg: constants, register map, state and pin carriers for the flash host controller.
// assumes a 250 MHz sys_clk and one asynchronous x8/x16 block flash on the far pins.
// Notes on behaviour
// RL1: array is 32 blocks of 16384 bytes, 256K words or 512K bytes.
// RL2: in x8 mode the extra low address line picks the byte.
// RL3: host starts writes and erases with two command writes; device then runs alone.
// RL4: a data write typically completes in about 13 us per byte, 20 us per word; the flash model uses T_WR_NS for both.
// RL5: block erase clears one of 32 blocks, typically about 0.6 seconds.
// RL6: one command erases every block not protected by its lock.
// RL7: x8 only, two-byte write takes three command writes, about 20 us.
// RL8: operations start only by write commands; progress shows in status and ready pin.
// RL9: host waits for the running operation to finish before asking another; bfci_host waits only when CMD_WAIT_RDY is set.
// RL10: block erase can be suspended for reads elsewhere, then resumed.
// RL11: each block has a lock bit; master protect refuses changes to locked blocks. The flash model keeps one lock flag for all blocks.
// RL12: after power-up or reset release all blocks act locked until protect-set sequence.
// RL13: erase-all-unlocked works straight after reset and honours real lock bits.
// RL14: ready/busy is open drain so many devices can share one line.
// RL15: reset pin low aborts, resets state machine, clears status, deep power-down.
// RL16: after reset pin rises, outputs invalid for 480 ns; host waits that long.
// RL17: host holds reset pin low at power-on and through power transitions.
// RL18: chip enable high with reset high is standby with outputs floating.
// RL19: oe low we high reads, both high floats, oe high we low writes.
// RL20: identifier read: address bit zero low maker code, high device code.
// RL21: width select low is x8 on the low data lines; high is x16.
// RL22: device latches address and data on the rising edge of write enable.
// RL23: ready/busy low while busy; floats when ready, suspended or powered down.
// RL24: erase and lock block number comes from byte address bits 18 to 14.
package bfci_pkg;

    localparam int CLK_PERIOD_NS = 4;
    localparam int BLOCK_COUNT   = 32;
    localparam int BLOCK_BYTES   = 16384;
    localparam int ADDR_W        = $clog2(BLOCK_COUNT * BLOCK_BYTES);
    localparam int DATA_W        = 16;
    localparam int SYNC_STAGES   = 2;

    // pin timing, in ns; plain defaults with margin for a slow part
    localparam int T_SETUP_NS    = 20;
    localparam int T_WE_LOW_NS   = 60;
    localparam int T_HOLD_NS     = 20;
    localparam int T_ACCESS_NS   = 100;
    localparam int T_RECOVER_NS  = 480;

    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int SETUP_CYC   = ns_to_cyc(T_SETUP_NS);
    localparam int WE_CYC      = ns_to_cyc(T_WE_LOW_NS);
    localparam int HOLD_CYC    = ns_to_cyc(T_HOLD_NS);
    localparam int ACC_CYC     = ns_to_cyc(T_ACCESS_NS) + SYNC_STAGES;
    localparam int RECOV_CYC   = ns_to_cyc(T_RECOVER_NS);
    localparam int CNT_W       = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_CMD    = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RDATA  = 8'h14;

    // field positions
    localparam int CTRL_RELEASE = 0;
    localparam int CTRL_WORD    = 1;
    localparam int CMD_WRITE    = 0;
    localparam int CMD_WAIT_RDY = 1;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_READY   = 1;
    localparam int STAT_RECOV   = 2;
    localparam int STAT_REFUSED = 3;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST  = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST   = 8'h00;

    typedef enum logic [2:0] {
        BFCI_IDLE, BFCI_WAIT, BFCI_SETUP, BFCI_STROBE, BFCI_HOLD
    } bfci_state_t;

    // strobes toward the flash, all active low
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } bfci_strobes_t;

    typedef struct packed {
        bfci_state_t         st;
        logic [CNT_W-1:0]    cnt;
        logic [CNT_W-1:0]    rec_cnt;
        logic                recovered;
        logic                release_rst;
        logic                word_mode;
        logic                kind_write;
        logic                wait_rdy;
        logic                refused;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W-1:0]   rdata;
        logic                ack;
        logic [31:0]         dat_o;
        bfci_strobes_t       strb;
        logic                drive;
    } bfci_host_state_t;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : lane_merge

endpackage : bfci_pkg

// file: bfci_sync.sv
// bfci_sync: plain two-flop synchroniser bank for pins that come from the flash.
// assumes inputs are asynchronous to sys_clk; stage one is read only by stage two.
`timescale 1ns/10ps
module bfci_sync
    import bfci_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_chk
        $error("bfci_sync: WIDTH must be at least 1");
    end

    // two flops, frozen with the rest of the block when clk_en is low
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : bfci_sync

// file: bfci_host.sv
// bfci_host: wishbone-driven pin sequencer for an asynchronous block flash.
// assumes classic wishbone from software; flash pins are asynchronous and sampled via bfci_sync.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
module bfci_host
    import bfci_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    // wishbone slave
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_we,
    input  wire logic [7:0]        wb_adr,
    input  wire logic [3:0]        wb_sel,
    input  wire logic [31:0]       wb_dat_w,
    output logic      [31:0]       wb_dat_r,
    output logic                   wb_ack,
    // flash pins
    output bfci_strobes_t          flash_strb,
    output logic                   powerdown_reset_n,
    output logic                   byte_n,
    output logic [ADDR_W-2:0]      flash_addr,
    output logic                   flash_a_low,
    output logic                   flash_a_low_oe,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_oe,
    input  wire logic              ready_busy_n
);

    bfci_host_state_t s;
    bfci_host_state_t next_s;
    logic [DATA_W-1:0] dq_sync;
    logic              rdy_sync;
    logic              bus_req;
    logic              cmd_wr;
    logic [31:0]       wmerge;

    if (RECOV_CYC > 255 || ACC_CYC > 255 || WE_CYC > 255) begin : g_chk
        $error("bfci_host: pin timing does not fit the 8-bit counters");
    end

    // data bus and ready line cross in through two flops each
    bfci_sync #(.WIDTH(DATA_W)) u_dq_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .async_in (dq_in),
        .sync_out (dq_sync)
    );

    // open-drain line shared by several parts; high only when all are ready
    bfci_sync #(.WIDTH(1)) u_rdy_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .async_in (ready_busy_n), // RL14 RL23
        .sync_out (rdy_sync)
    );

    assign bus_req = wb_cyc && wb_stb && !s.ack;
    assign cmd_wr  = bus_req && wb_we && (wb_adr == OFS_CMD);

    // register file, recovery timer and pin sequencer in one next-state pass
    always_comb begin
        next_s     = s;
        next_s.ack = 1'b0;
        wmerge     = 32'h0000_0000;

        // recovery interval after the reset pin is released
        if (s.rec_cnt != CNT_RST) begin
            next_s.rec_cnt = s.rec_cnt - 8'h01;
            if (s.rec_cnt == 8'h01) begin
                next_s.recovered = 1'b1; // RL16
            end
        end

        // wishbone: one-cycle registered answer, unmapped reads give zero
        if (bus_req) begin
            next_s.ack = 1'b1;
            if (wb_we) begin
                unique case (wb_adr)
                    OFS_CTRL: begin
                        wmerge = lane_merge({30'h0, s.word_mode, s.release_rst},
                                            wb_dat_w, wb_sel);
                        next_s.word_mode   = wmerge[CTRL_WORD]; // RL21
                        next_s.release_rst = wmerge[CTRL_RELEASE];
                        if (!wmerge[CTRL_RELEASE]) begin
                            // pin low again: device is in power-down, outputs invalid
                            next_s.recovered = 1'b0; // RL15
                            next_s.rec_cnt   = CNT_RST;
                        end else if (!s.release_rst) begin
                            next_s.recovered = 1'b0;
                            next_s.rec_cnt   = 8'(RECOV_CYC); // RL16
                        end
                    end
                    OFS_ADDR: begin
                        wmerge      = lane_merge({13'h0, s.addr}, wb_dat_w, wb_sel);
                        next_s.addr = wmerge[ADDR_W-1:0]; // RL1 RL24
                    end
                    OFS_WDATA: begin
                        wmerge       = lane_merge({16'h0, s.wdata}, wb_dat_w, wb_sel);
                        next_s.wdata = wmerge[DATA_W-1:0];
                    end
                    OFS_CMD: begin // RL3 RL7 RL12
                        // one pin cycle per command; refused while a cycle runs
                        if (s.st == BFCI_IDLE) begin
                            next_s.st         = BFCI_WAIT;
                            next_s.kind_write = wb_dat_w[CMD_WRITE];
                            next_s.wait_rdy   = wb_dat_w[CMD_WAIT_RDY]; // RL9
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end
                    OFS_STATUS: begin
                        // writing one clears the refused flag
                        if (wb_sel[0] && wb_dat_w[STAT_REFUSED]) begin
                            next_s.refused = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (wb_adr)
                    OFS_CTRL:   next_s.dat_o = {30'h0, s.word_mode, s.release_rst};
                    OFS_ADDR:   next_s.dat_o = {13'h0, s.addr};
                    OFS_WDATA:  next_s.dat_o = {16'h0, s.wdata};
                    OFS_STATUS: next_s.dat_o = {28'h0, s.refused, s.recovered, rdy_sync,
                                                (s.st != BFCI_IDLE)}; // RL8
                    OFS_RDATA:  next_s.dat_o = {16'h0, s.rdata};
                    default:    next_s.dat_o = 32'h0000_0000;
                endcase
            end
        end

        // pin sequencer
        unique case (s.st)
            BFCI_IDLE: begin
                next_s.strb  = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1}; // RL18
                next_s.drive = 1'b0;
            end
            BFCI_WAIT: begin
                // no pin cycle before recovery, and optionally not while busy
                if (s.recovered && (!s.wait_rdy || rdy_sync)) begin // RL16 RL9
                    next_s.st        = BFCI_SETUP;
                    next_s.strb.ce_n = 1'b0;
                    next_s.drive     = s.kind_write;
                    next_s.cnt       = 8'(SETUP_CYC - 1);
                end
            end
            BFCI_SETUP: begin
                if (s.cnt == CNT_RST) begin
                    next_s.st = BFCI_STROBE;
                    if (s.kind_write) begin
                        next_s.strb.we_n = 1'b0; // RL19
                        next_s.cnt       = 8'(WE_CYC - 1);
                    end else begin
                        next_s.strb.oe_n = 1'b0; // RL19
                        next_s.cnt       = 8'(ACC_CYC - 1);
                    end
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            BFCI_STROBE: begin
                if (s.cnt == CNT_RST) begin
                    next_s.st  = BFCI_HOLD;
                    next_s.cnt = 8'(HOLD_CYC - 1);
                    if (s.kind_write) begin
                        // address and data stay put across the rising edge
                        next_s.strb.we_n = 1'b1; // RL22
                    end else begin
                        next_s.strb.oe_n = 1'b1;
                        next_s.rdata     = s.word_mode ? dq_sync
                                                       : {8'h00, dq_sync[7:0]}; // RL21
                    end
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            BFCI_HOLD: begin
                if (s.cnt == CNT_RST) begin
                    next_s.st        = BFCI_IDLE;
                    next_s.strb.ce_n = 1'b1;
                    next_s.drive     = 1'b0;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            default: begin
                next_s.st = BFCI_IDLE;
            end
        endcase

        // a new refusal in the clearing cycle still stands
        if (cmd_wr && s.st != BFCI_IDLE) begin
            next_s.refused = 1'b1;
        end
    end

    // whole state in one register; reset keeps the flash in power-down
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s             <= '0;
            s.st          <= BFCI_IDLE;
            s.addr        <= ADDR_RST;
            s.wdata       <= DATA_RST;
            s.rdata       <= DATA_RST;
            s.strb        <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            s.release_rst <= 1'b0; // RL17
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // pin outputs, all from flops
    assign wb_ack            = s.ack;
    assign wb_dat_r          = s.dat_o;
    assign flash_strb        = s.strb;
    assign powerdown_reset_n = s.release_rst; // RL17 RL15
    assign byte_n            = s.word_mode; // RL21
    assign flash_addr        = s.addr[ADDR_W-1:1];
    // extra low line only carries the byte select in x8 mode
    assign flash_a_low       = s.addr[0]; // RL2
    assign flash_a_low_oe    = !s.word_mode && !s.strb.ce_n; // RL2
    assign dq_out            = s.word_mode ? s.wdata : {8'h00, s.wdata[7:0]};
    // high byte floats in x8 mode; bus is never driven while oe_n is low
    assign dq_oe             = s.drive ? (s.word_mode ? 16'hffff : 16'h00ff)
                                       : 16'h0000; // RL19 RL21

endmodule : bfci_host

// file: bfci_host_sva.sv
// bfci_host_sva: port checks for bfci_host, bound to every instance.
// assumes clk_en stays high while traffic runs.
`timescale 1ns/10ps
module bfci_host_sva
    import bfci_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              srst,
    input wire logic              clk_en,
    input wire logic              wb_cyc,
    input wire logic              wb_stb,
    input wire logic              wb_ack,
    input wire bfci_strobes_t     flash_strb,
    input wire logic              powerdown_reset_n,
    input wire logic              byte_n,
    input wire logic [ADDR_W-2:0] flash_addr,
    input wire logic              flash_a_low_oe,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic [DATA_W-1:0] dq_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    logic [7:0] up_cyc;
    // cycles since the reset pin rose, saturating so it never wraps
    always_ff @(posedge sys_clk) begin
        if (srst || !powerdown_reset_n) begin
            up_cyc <= 8'h00;
        end else if (clk_en && up_cyc != 8'hff) begin
            up_cyc <= up_cyc + 8'h01;
        end
    end
    sequence s_we_low;
        (!flash_strb.we_n && !flash_strb.ce_n && $stable(dq_out))[*5];
    endsequence
    sequence s_we_hold;
        (flash_strb.we_n && !flash_strb.ce_n && $stable(dq_out) && $stable(flash_addr))[*5];
    endsequence
    property p_ack_answer;
        wb_cyc && wb_stb && !wb_ack && clk_en |=> wb_ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack && clk_en |=> !wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_pd_quiet;
        !powerdown_reset_n |-> flash_strb.ce_n && dq_oe == 16'h0000;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("pins busy in power-down");
    property p_recovery;
        !flash_strb.ce_n |-> up_cyc >= 8'd120;
    endproperty
    a_recovery: assert property (p_recovery) else $error("access before recovery");
    property p_no_contention;
        !flash_strb.oe_n |-> flash_strb.we_n && dq_oe == 16'h0000;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("read while driving");
    property p_we_pulse;
        $fell(flash_strb.we_n) |-> s_we_low ##1 s_we_low ##1 s_we_low ##1 s_we_hold;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe shape wrong");
    property p_lane_width;
        dq_oe != 16'h0000 |-> dq_oe == (byte_n ? 16'hffff : 16'h00ff);
    endproperty
    a_lane_width: assert property (p_lane_width) else $error("driven lanes wrong");
    property p_byte_sel;
        flash_a_low_oe |-> !byte_n;
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("byte select in x16");
endmodule : bfci_host_sva
bind bfci_host bfci_host_sva u_sva (.*);

// file: bfci_flash_model.sv
// bfci_flash_model: behavioural block flash facing bfci_host.
// assumes a bench pull-up on the ready line and shrunk long times.
`timescale 1ns/10ps
module bfci_flash_model
    import bfci_pkg::*;
#(
    parameter int          T_WR_NS  = 13000,
    parameter int          T_ER_NS  = 600000000,
    parameter logic [15:0] MAKER_ID = 16'h00c5, // arbitrary value
    parameter logic [15:0] DEV_ID   = 16'h0a3e  // arbitrary value
) (
    input  wire bfci_strobes_t     flash_strb,
    input  wire logic              powerdown_reset_n,
    input  wire logic              byte_n,
    input  wire logic [ADDR_W-2:0] flash_addr,
    input  wire logic              flash_a_low,
    input  wire logic              flash_a_low_oe,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic [DATA_W-1:0] dq_oe,
    output logic      [DATA_W-1:0] dq_in,
    output logic                   rb_pull_low
);
    logic [7:0]  mem [int]; // missing byte reads as erased
    logic [7:0]  compat_status_reg  = 8'h00;
    logic [7:0]  cmd  = 8'hff;
    logic [7:0]  mode = 8'hff;
    logic        busy = 1'b0;
    logic        open = 1'b0;
    logic [15:0] fz   = 16'ha5c3;
    logic [15:0] d;
    logic [15:0] rd;
    int          ba;
    int          blk;
    realtime     t_up = 0;
    // undriven lines wander, so a stale value never passes
    always #3 fz = ~fz;
    assign rb_pull_low = busy && powerdown_reset_n;
    assign ba = byte_n ? {flash_addr, 1'b0} : {flash_addr, flash_a_low_oe ? flash_a_low : fz[0]};
    function automatic logic [7:0] rb(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : rb
    // power-down aborts and forgets all volatile state
    always @(negedge powerdown_reset_n) begin
        busy = 1'b0;
        compat_status_reg  = 8'h00;
        mode = 8'hff;
        cmd  = 8'hff;
        open = 1'b0;
    end
    always @(posedge powerdown_reset_n) t_up = $realtime;
    // commands taken as write enable rises
    always @(posedge flash_strb.we_n) begin
        d = (dq_out & dq_oe) | (fz & ~dq_oe);
        blk = ba - ba % BLOCK_BYTES;
        if (!flash_strb.ce_n && powerdown_reset_n && !busy) begin
            case (cmd)
                8'h40, 8'h10: begin
                    if (open) begin
                        mem[ba] = d[7:0];
                        if (byte_n)
                            mem[ba+1] = d[15:8];
                    end else
                        compat_status_reg[4] = 1'b1;
                    busy = 1'b1;
                    busy <= #(T_WR_NS) 1'b0;
                    cmd = 8'h00;
                end
                8'h20: begin
                    for (int k = blk; k < blk + BLOCK_BYTES && open && d[7:0] == 8'hd0; k++)
                        mem.delete(k);
                    compat_status_reg[5] = !open;
                    busy = 1'b1;
                    busy <= #(T_ER_NS) 1'b0;
                    cmd = 8'h00;
                end
                8'h57: begin
                    open = open || d[7:0] == 8'hd0;
                    cmd = 8'h00;
                end
                default: begin
                    cmd  = d[7:0];
                    mode = d[7:0];
                    if (d[7:0] == 8'h50)
                        compat_status_reg = 8'h00;
                end
            endcase
        end
    end
    // read path floats outside a settled, recovered read
    always @* begin
        rd = mode == 8'h90 ? (|flash_addr[17:1] ? 16'h0 : flash_addr[0] ? DEV_ID : MAKER_ID)
           : mode == 8'hff ? {rb(ba + 1), rb(ba)} : {8'h00, ~busy, compat_status_reg[6:0]};
        dq_in = fz;
        if (!flash_strb.ce_n && !flash_strb.oe_n && powerdown_reset_n && $realtime - t_up >= 480)
            dq_in = byte_n ? rd : {fz[15:8], rd[7:0]};
    end
endmodule : bfci_flash_model

// file: bfci_host_tb.sv
// bfci_host_tb: bench for bfci_host with a behavioural flash.
// assumes the flash model and bound checker are compiled too.
`timescale 1ns/10ps
module bfci_host_tb
    import bfci_pkg::*;
;
    localparam logic [15:0] MK = 16'h00c5; // arbitrary value
    localparam logic [15:0] DV = 16'h0a3e; // arbitrary value
    logic              sys_clk  = 1'b0;
    logic              srst     = 1'b1;
    logic              wb_cyc   = 1'b0;
    logic              wb_stb   = 1'b0;
    logic              wb_we    = 1'b0;
    logic [7:0]        wb_adr   = 8'h00;
    logic [31:0]       wb_dat_w = 32'h0;
    logic [31:0]       wb_dat_r, rd;
    logic              wb_ack, powerdown_reset_n, byte_n, flash_a_low, flash_a_low_oe, rb_low;
    bfci_strobes_t     flash_strb;
    logic [ADDR_W-2:0] flash_addr;
    logic [DATA_W-1:0] dq_in, dq_out, dq_oe;
    wire               ready_busy_n = ~rb_low; // pull-up unless the device sinks it
    int                failures = 0;
    int                n_checks = 0;
    logic [1:0]        r_ctl [6] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1};
    logic [18:0]       r_adr [6] = '{19'h0, 19'h2, 19'h4, 19'h0, 19'h3, 19'h6};
    logic [15:0]       r_exp [6] = '{MK, DV, 16'h0, {8'h0, MK[7:0]}, {8'h0, DV[7:0]}, 16'h0};
    always #2 sys_clk = ~sys_clk;
    bfci_host uut (.clk_en(1'b1), .wb_sel(4'hf), .*);
    bfci_flash_model #(.T_WR_NS(2000), .T_ER_NS(20000), .MAKER_ID(MK), .DEV_ID(DV)) flash (
        .rb_pull_low(rb_low), .*);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_w <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 40)
            check("wb_ack", wb_ack, 1'b1);
    endtask : wb
    task automatic idle();
        rd = 32'h1;
        for (int i = 0; i < 3000 && rd[STAT_BUSY] !== 1'b0; i++)
            wb(1'b0, OFS_STATUS, 32'h0);
    endtask : idle
    task automatic pin(input logic [3:0] c, input logic [18:0] a, input logic [15:0] d);
        wb(1'b1, OFS_ADDR, {13'h0, a});
        wb(1'b1, OFS_WDATA, {16'h0, d});
        wb(1'b1, OFS_CMD, {28'h0, c});
        idle();
    endtask : pin
    task automatic frd(input logic [3:0] c, input logic [18:0] a);
        pin(c, a, 16'h0);
        wb(1'b0, OFS_RDATA, 32'h0);
    endtask : frd
    task automatic stop_test();
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // watchdog sized well past the expected ten thousand cycles
    initial begin
        #160000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        check("rst pin", powerdown_reset_n, 1'b0);
        wb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl", rd, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        wb(1'b0, OFS_STATUS, 32'h0);
        check("status", rd, 32'h2);
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, OFS_CTRL, {30'h0, r_ctl[i]});
            pin(4'h1, 19'h0, 16'h0090);
            frd(4'h0, r_adr[i]);
            check("ident", rd, {16'h0, r_exp[i]});
        end
        // write refused while still locked, then power-down clears the flag
        wb(1'b1, OFS_CTRL, 32'h3);
        pin(4'h1, 19'h100, 16'h0040);
        pin(4'h1, 19'h100, 16'h1234);
        pin(4'h3, 19'h0, 16'h0070);
        frd(4'h0, 19'h0);
        check("locked", rd, 32'h90);
        wb(1'b1, OFS_CTRL, 32'h2);
        wb(1'b0, OFS_STATUS, 32'h0);
        check("pd pin", powerdown_reset_n, 1'b0);
        check("recov", rd[STAT_RECOV], 1'b0);
        wb(1'b1, OFS_CTRL, 32'h3);
        pin(4'h1, 19'h0, 16'h0070);
        frd(4'h0, 19'h0);
        check("csr clr", rd, 32'h80);
        pin(4'h1, 19'h0, 16'h00ff);
        frd(4'h0, 19'h100);
        check("kept", rd, 32'hffff);
        pin(4'h1, 19'h0, 16'h0057);
        pin(4'h1, 19'h1fe, 16'h00d0);
        pin(4'h1, 19'h100, 16'h0040);
        pin(4'h1, 19'h100, 16'h1234);
        check("rdy low", rd[STAT_READY], 1'b0);
        pin(4'h3, 19'h0, 16'h00ff);
        frd(4'h0, 19'h100);
        check("word", rd, 32'h1234);
        wb(1'b1, OFS_CTRL, 32'h1);
        pin(4'h1, 19'h4001, 16'h0040);
        pin(4'h1, 19'h4001, 16'h00ab);
        pin(4'h3, 19'h0, 16'h00ff);
        frd(4'h0, 19'h4001);
        check("byte hi", rd, 32'hab);
        frd(4'h0, 19'h100);
        check("byte lo", rd, 32'h34);
        pin(4'h3, 19'h0, 16'h0020);
        pin(4'h1, 19'h3abc, 16'h00d0);
        pin(4'h3, 19'h0, 16'h00ff);
        frd(4'h0, 19'h100);
        check("erased", rd, 32'hff);
        frd(4'h0, 19'h4001);
        check("other blk", rd, 32'hab);
        // second command while a pin cycle runs
        wb(1'b1, OFS_CMD, 32'h0);
        wb(1'b1, OFS_CMD, 32'h0);
        wb(1'b0, OFS_STATUS, 32'h0);
        check("refused", rd[STAT_REFUSED], 1'b1);
        idle();
        wb(1'b1, OFS_STATUS, 32'h8);
        wb(1'b0, OFS_STATUS, 32'h0);
        check("unrefused", rd[STAT_REFUSED], 1'b0);
        stop_test();
    end
endmodule : bfci_host_tb
